// ### core/pic_top.sv
// Prioritised interrupt controller with AHB-Lite register access
`timescale 1ns/1ps
module pic_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // External interrupt pins
  input  wire logic [3:0]  ext_pin,
  // Peripheral events
  input  wire logic        uart_rx_done,
  input  wire logic        uart_tx_done,
  input  wire logic [3:0]  timer_match,
  input  wire logic        adc_done,
  input  wire logic        interval_overflow,
  input  wire logic        watchdog_match,
  input  wire logic        watchdog_reset_select,
  input  wire logic        watch_period,
  // Processor core
  input  wire logic        insn_done,
  input  wire logic        brk_request,
  input  wire logic [15:0] return_pc,
  input  wire logic        psw_restore,
  input  wire logic [7:0]  psw_restore_data,
  output logic             core_hold,
  output logic             pc_load,
  output logic      [15:0] pc_vector,
  output logic             stack_we,
  output logic      [7:0]  stack_addr,
  output logic      [7:0]  stack_wdata,
  output logic             master_enable
);
  localparam int NSRC = pic_pkg::NSRC;

  typedef enum logic [2:0] {ST_BOOT, ST_IDLE, ST_PUSH, ST_FETCH, ST_LOAD} pic_state_e;

  pic_link_if lnk ();

  pic_edge_detect #(.N(pic_pkg::NEXT)) u_edge (
    .clk  (clk),
    .srst (srst),
    .pin  (ext_pin),
    .lnk  (lnk.edge_mp)
  );

  pic_priority u_prio (
    .lnk (lnk.enc_mp)
  );

  // Registers
  logic [NSRC-1:0] req_r;
  logic [NSRC-1:0] en_r;
  logic [NSRC-1:0] pend_r;
  logic [7:0]      edge_sel_r;
  logic [7:0]      psw_r;
  logic [7:0]      sp_r;
  pic_state_e      state_r;
  logic [3:0]      cnt_r;
  logic [15:0]     vec_r;
  logic [15:0]     ret_pc_r;
  logic [7:0]      psw_save_r;
  localparam int IDXW = pic_pkg::IDX_W;
  logic [IDXW:0]   last_idx_r;

  // Bus state
  logic            wr_pend_r;
  logic [7:0]      wr_off_r;
  logic [31:0]     hrdata_r;

  // Core side output flops
  logic            core_hold_r;
  logic            pc_load_r;
  logic [15:0]     pc_vector_r;
  logic            stack_we_r;
  logic [7:0]      stack_addr_r;
  logic [7:0]      stack_wdata_r;

  // Combinational
  logic [NSRC-1:0] src_set;
  logic            addr_acc;
  logic            wr_en;
  logic [7:0]      wdat;
  logic [NSRC-1:0] req_wmask;
  logic [NSRC-1:0] req_wval;
  logic [NSRC-1:0] en_wmask;
  logic [NSRC-1:0] en_wval;
  logic [NSRC-1:0] pend_wmask;
  logic [NSRC-1:0] pend_wval;
  logic            take_irq;
  logic            take_brk;

  // Gathers a source vector into one 8-bit register image
  function automatic logic [7:0] pack_req(input logic [NSRC-1:0] v, input logic [1:0] g);
    pack_req = 8'h00;
    for (int i = 0; i < NSRC; i++) begin
      if (pic_pkg::req_grp(i) == g) pack_req[pic_pkg::req_bit(i)] = v[i];
    end
  endfunction : pack_req

  function automatic logic [7:0] pack_pend(input logic [NSRC-1:0] v, input logic [1:0] g);
    pack_pend = 8'h00;
    for (int i = 0; i < NSRC; i++) begin
      if (pic_pkg::pend_grp(i) == g) pack_pend[pic_pkg::pend_bit(i)] = v[i];
    end
  endfunction : pack_pend

  function automatic logic [31:0] read_mux(input logic [7:0] off);
    unique case (off)
      pic_pkg::OFF_EN_HIGH:   read_mux = {24'h0, pack_req(en_r, 2'h0)};
      pic_pkg::OFF_EN_MID:    read_mux = {24'h0, pack_req(en_r, 2'h1)};
      pic_pkg::OFF_EN_LOW:    read_mux = {24'h0, pack_req(en_r, 2'h2)};
      pic_pkg::OFF_REQ_HIGH:  read_mux = {24'h0, pack_req(req_r, 2'h0)};
      pic_pkg::OFF_REQ_MID:   read_mux = {24'h0, pack_req(req_r, 2'h1)};
      pic_pkg::OFF_REQ_LOW:   read_mux = {24'h0, pack_req(req_r, 2'h2)};
      pic_pkg::OFF_PEND_HIGH: read_mux = {24'h0, pack_pend(pend_r, 2'h0)};
      pic_pkg::OFF_PEND_LOW:  read_mux = {24'h0, pack_pend(pend_r, 2'h1)};
      pic_pkg::OFF_PSW:       read_mux = {24'h0, psw_r};
      pic_pkg::OFF_SP:        read_mux = {24'h0, sp_r};
      pic_pkg::OFF_STATUS:    read_mux = {23'h0, last_idx_r, 3'h0, core_hold_r};
      pic_pkg::OFF_EDGE_SEL:  read_mux = {24'h0, edge_sel_r};
      default:                read_mux = 32'h0;
    endcase
  endfunction : read_mux

  // Event sources in priority order
  always_comb begin
    src_set[3:0]  = lnk.ext_edge;
    src_set[4]    = uart_rx_done;
    src_set[5]    = uart_tx_done;
    src_set[9:6]  = timer_match;
    src_set[10]   = adc_done;
    src_set[11]   = interval_overflow;
    src_set[12]   = watchdog_match & ~watchdog_reset_select;
    src_set[13]   = watch_period;
  end

  // AHB-Lite address phase, zero wait states
  assign addr_acc = hsel & hready & htrans[1];
  assign wr_en    = wr_pend_r;
  assign wdat     = hwdata[7:0];

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_pend_r <= 1'b0;
      wr_off_r  <= 8'h00;
      hrdata_r  <= 32'h0;
    end else begin
      wr_pend_r <= addr_acc & hwrite;
      if (addr_acc) wr_off_r <= haddr[7:0];
      if (addr_acc && !hwrite) hrdata_r <= read_mux(haddr[7:0]);
    end
  end

  // Write masks per source vector
  always_comb begin
    req_wmask  = '0;
    req_wval   = '0;
    en_wmask   = '0;
    en_wval    = '0;
    pend_wmask = '0;
    pend_wval  = '0;
    for (int i = 0; i < NSRC; i++) begin
      if (wr_en && wr_off_r == pic_pkg::OFF_REQ_HIGH + 8'(pic_pkg::req_grp(i)) * 8'h04) begin
        req_wmask[i] = 1'b1;
        req_wval[i]  = wdat[pic_pkg::req_bit(i)];
      end
      if (wr_en && wr_off_r == pic_pkg::OFF_EN_HIGH + 8'(pic_pkg::req_grp(i)) * 8'h04) begin
        en_wmask[i] = 1'b1;
        en_wval[i]  = wdat[pic_pkg::req_bit(i)];
      end
      if (wr_en && wr_off_r == pic_pkg::OFF_PEND_HIGH + 8'(pic_pkg::pend_grp(i)) * 8'h04) begin
        pend_wmask[i] = 1'b1;
        pend_wval[i]  = wdat[pic_pkg::pend_bit(i)];
      end
    end
  end

  // Request flags: events win over a software write; acceptance leaves them alone
  always_ff @(posedge clk) begin
    if (srst) begin
      req_r <= '0;
    end else begin
      req_r <= (req_r & ~req_wmask) | (req_wval & req_wmask) | src_set;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      en_r <= '0;
    end else begin
      en_r <= (en_r & ~en_wmask) | (en_wval & en_wmask);
    end
  end

  // Pending flags: only software can clear them
  always_ff @(posedge clk) begin
    if (srst) begin
      pend_r <= '0;
    end else begin
      pend_r <= (pend_r & ~pend_wmask) | (pend_wval & pend_wmask) | (req_r & en_r);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      edge_sel_r <= pic_pkg::EDGE_RESET;
    end else if (wr_en && wr_off_r == pic_pkg::OFF_EDGE_SEL) begin
      edge_sel_r <= wdat;
    end
  end

  assign lnk.edge_sel   = edge_sel_r;
  assign lnk.candidates = req_r & en_r;

  // Acceptance decision at the end of an instruction
  assign take_irq = (state_r == ST_IDLE) && insn_done && psw_r[pic_pkg::PSW_IME_BIT] &&
                    lnk.winner_valid;
  assign take_brk = (state_r == ST_IDLE) && insn_done && !take_irq && brk_request;

  // Status word: acceptance clears master enable ahead of software or return restore
  always_ff @(posedge clk) begin
    if (srst) begin
      psw_r <= pic_pkg::PSW_RESET;
    end else if (take_irq || take_brk) begin
      psw_r[pic_pkg::PSW_IME_BIT] <= 1'b0;
      psw_r[pic_pkg::PSW_BRK_BIT] <= take_brk;
    end else if (psw_restore) begin
      psw_r <= psw_restore_data;
    end else if (wr_en && wr_off_r == pic_pkg::OFF_PSW) begin
      psw_r <= wdat;
    end
  end

  // Acceptance sequencer
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r    <= ST_BOOT;
      cnt_r      <= 4'h0;
      vec_r      <= pic_pkg::VEC_RESET;
      ret_pc_r   <= 16'h0000;
      psw_save_r <= 8'h00;
      last_idx_r <= '0;
    end else begin
      unique case (state_r)
        ST_BOOT: begin
          state_r <= ST_IDLE;
        end
        ST_IDLE: begin
          if (take_irq || take_brk) begin
            state_r    <= ST_PUSH;
            cnt_r      <= 4'h1;
            ret_pc_r   <= return_pc;
            psw_save_r <= psw_r;
            vec_r      <= take_irq ? pic_pkg::vector_of(lnk.winner_idx) : pic_pkg::VEC_BRK;
            if (take_irq) last_idx_r <= {1'b0, lnk.winner_idx} + 5'h01;
          end
        end
        ST_PUSH: begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == 4'(pic_pkg::PUSH_COUNT)) state_r <= ST_FETCH;
        end
        ST_FETCH: begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == 4'(pic_pkg::ACCEPT_CYCLES - 2)) state_r <= ST_LOAD;
        end
        ST_LOAD: begin
          cnt_r   <= 4'h0;
          state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Stack pushes: high return byte, low return byte, status word
  always_ff @(posedge clk) begin
    if (srst) begin
      sp_r          <= pic_pkg::SP_RESET;
      stack_we_r    <= 1'b0;
      stack_addr_r  <= 8'h00;
      stack_wdata_r <= 8'h00;
    end else if (state_r == ST_PUSH) begin
      stack_we_r   <= 1'b1;
      stack_addr_r <= sp_r;
      sp_r         <= sp_r - 8'h01;
      unique case (cnt_r)
        4'h1:    stack_wdata_r <= ret_pc_r[15:8];
        4'h2:    stack_wdata_r <= ret_pc_r[7:0];
        default: stack_wdata_r <= psw_save_r;
      endcase
    end else begin
      stack_we_r <= 1'b0;
      if (wr_en && wr_off_r == pic_pkg::OFF_SP) sp_r <= wdat;
    end
  end

  // Program counter load after boot and at the end of acceptance
  always_ff @(posedge clk) begin
    if (srst) begin
      pc_load_r   <= 1'b0;
      pc_vector_r <= pic_pkg::VEC_RESET;
      core_hold_r <= 1'b1;
    end else begin
      pc_load_r   <= (state_r == ST_BOOT) || (state_r == ST_LOAD);
      pc_vector_r <= (state_r == ST_LOAD) ? vec_r : pc_vector_r;
      core_hold_r <= (state_r != ST_IDLE) ? (state_r != ST_LOAD) && (state_r != ST_BOOT)
                                          : (take_irq || take_brk);
    end
  end

  assign hrdata        = hrdata_r;
  assign hreadyout     = 1'b1;
  assign hresp         = 1'b0;
  assign core_hold     = core_hold_r;
  assign pc_load       = pc_load_r;
  assign pc_vector     = pc_vector_r;
  assign stack_we      = stack_we_r;
  assign stack_addr    = stack_addr_r;
  assign stack_wdata   = stack_wdata_r;
  assign master_enable = psw_r[pic_pkg::PSW_IME_BIT];

  logic unused_bits;
  assign unused_bits = ^{haddr[31:8], hsize, hwdata[31:8], htrans[0]};
endmodule : pic_top

// ### core/pic_pkg.sv
// Shared constants, source map and vector table of the interrupt controller
package pic_pkg;

  localparam int NSRC = 14;
  localparam int NEXT = 4;
  localparam int IDX_W = 4;

  // Register byte offsets
  localparam logic [7:0] OFF_EN_HIGH   = 8'h00;
  localparam logic [7:0] OFF_EN_MID    = 8'h04;
  localparam logic [7:0] OFF_EN_LOW    = 8'h08;
  localparam logic [7:0] OFF_REQ_HIGH  = 8'h0c;
  localparam logic [7:0] OFF_REQ_MID   = 8'h10;
  localparam logic [7:0] OFF_REQ_LOW   = 8'h14;
  localparam logic [7:0] OFF_PEND_HIGH = 8'h18;
  localparam logic [7:0] OFF_PEND_LOW  = 8'h1c;
  localparam logic [7:0] OFF_PSW       = 8'h20;
  localparam logic [7:0] OFF_SP        = 8'h24;
  localparam logic [7:0] OFF_STATUS    = 8'h28;
  localparam logic [7:0] OFF_EDGE_SEL  = 8'hfc;

  // Status word fields and reset values
  localparam int PSW_IME_BIT = 2;
  localparam int PSW_BRK_BIT = 4;
  localparam logic [7:0] PSW_RESET  = 8'h00;
  localparam logic [7:0] SP_RESET   = 8'hff;
  localparam logic [7:0] EDGE_RESET = 8'h00;

  // Edge selection codes, two bits per external input
  localparam logic [1:0] EDGE_OFF  = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_RISE = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // Acceptance timing
  localparam int ACCEPT_OSC_PERIODS = 8;
  localparam int OSC_PERIOD_PS      = 4000;
  localparam int CLK_PERIOD_PS      = 4000;
  localparam int ACCEPT_CYCLES =
    (ACCEPT_OSC_PERIODS * OSC_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PUSH_COUNT = 3;

  // Vectors
  localparam logic [15:0] VEC_RESET = 16'hfffe;
  localparam logic [15:0] VEC_BRK   = 16'hffde;

  function automatic logic [15:0] vector_of(input logic [IDX_W-1:0] idx);
    unique case (idx)
      4'h0: vector_of = 16'hfffa;
      4'h1: vector_of = 16'hfff8;
      4'h2: vector_of = 16'hfff6;
      4'h3: vector_of = 16'hfff4;
      4'h4, 4'h5: vector_of = 16'hfff2;
      4'h6: vector_of = 16'hffee;
      4'h7: vector_of = 16'hffec;
      4'h8: vector_of = 16'hffea;
      4'h9: vector_of = 16'hffe8;
      4'ha: vector_of = 16'hffe4;
      4'hb: vector_of = 16'hffe2;
      default: vector_of = 16'hffe0;
    endcase
  endfunction : vector_of

  // Request and enable layout: group 0 high, 1 mid, 2 low
  function automatic logic [1:0] req_grp(input int i);
    unique case (i)
      0, 1, 2, 4, 5: req_grp = 2'h0;
      3, 12, 13:     req_grp = 2'h2;
      default:       req_grp = 2'h1;
    endcase
  endfunction : req_grp

  function automatic int req_bit(input int i);
    unique case (i)
      0: req_bit = 6;
      1: req_bit = 5;
      2: req_bit = 4;
      3: req_bit = 5;
      4: req_bit = 3;
      5: req_bit = 2;
      12: req_bit = 7;
      13: req_bit = 6;
      default: req_bit = 13 - i;
    endcase
  endfunction : req_bit

  // Pending layout: group 0 high, 1 low
  function automatic logic [1:0] pend_grp(input int i);
    pend_grp = (i == 3 || i >= 9) ? 2'h1 : 2'h0;
  endfunction : pend_grp

  function automatic int pend_bit(input int i);
    unique case (i)
      0: pend_bit = 7;
      1: pend_bit = 6;
      2: pend_bit = 5;
      3: pend_bit = 2;
      default: pend_bit = (i <= 8) ? 8 - i : 16 - i;
    endcase
  endfunction : pend_bit

endpackage : pic_pkg

// ### core/pic_link_if.sv
// Internal links between the controller and its edge and priority helpers
`timescale 1ns/1ps
interface pic_link_if;
  logic [pic_pkg::NEXT-1:0]  ext_edge;
  logic [7:0]                edge_sel;
  logic [pic_pkg::NSRC-1:0]  candidates;
  logic                      winner_valid;
  logic [pic_pkg::IDX_W-1:0] winner_idx;

  modport edge_mp (output ext_edge, input edge_sel);
  modport enc_mp  (input candidates, output winner_valid, winner_idx);
  modport top_mp  (input ext_edge, winner_valid, winner_idx, output edge_sel, candidates);
endinterface : pic_link_if

// ### core/pic_edge_detect.sv
// Synchronises the external interrupt pins and detects the selected transitions
`timescale 1ns/1ps
module pic_edge_detect #(
  parameter int N = pic_pkg::NEXT
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         srst,
  // Pins
  input  wire logic [N-1:0] pin,
  // Link
  pic_link_if.edge_mp       lnk
);
  if (N < 1 || N > 4) begin : g_bad_n
    $error("pic_edge_detect: N must be 1 to 4");
  end

  logic [N-1:0] meta_r;
  logic [N-1:0] sync_r;
  logic [N-1:0] prev_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= pin;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  always_comb begin
    lnk.ext_edge = '0;
    for (int i = 0; i < N; i++) begin
      unique case (lnk.edge_sel[2*i +: 2])
        pic_pkg::EDGE_FALL: lnk.ext_edge[i] = prev_r[i] & ~sync_r[i];
        pic_pkg::EDGE_RISE: lnk.ext_edge[i] = ~prev_r[i] & sync_r[i];
        pic_pkg::EDGE_BOTH: lnk.ext_edge[i] = prev_r[i] ^ sync_r[i];
        pic_pkg::EDGE_OFF:  lnk.ext_edge[i] = 1'b0;
      endcase
    end
  end
endmodule : pic_edge_detect

// ### core/pic_priority.sv
// Fixed priority pick: the lowest index among the candidates wins
`timescale 1ns/1ps
module pic_priority (
  // Link
  pic_link_if.enc_mp lnk
);
  always_comb begin
    lnk.winner_valid = 1'b0;
    lnk.winner_idx   = '0;
    for (int i = pic_pkg::NSRC - 1; i >= 0; i--) begin
      if (lnk.candidates[i]) begin
        lnk.winner_valid = 1'b1;
        lnk.winner_idx   = pic_pkg::IDX_W'(i);
      end
    end
  end
endmodule : pic_priority

// ### tb/pic_core_model.sv
// Processor core model: retires instructions and stalls while acceptance runs
`timescale 1ns/1ps
module pic_core_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Controller side
  input  wire logic        core_hold,
  input  wire logic        pc_load,
  input  wire logic [15:0] pc_vector,
  output logic             insn_done,
  output logic      [15:0] return_pc
);
  logic [1:0] step_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      step_r <= 2'h0;
      insn_done <= 1'b0;
      return_pc <= 16'h0100;
    end else begin
      step_r <= step_r + 2'h1;
      insn_done <= (step_r == 2'h2) && !core_hold && !pc_load;
      if (pc_load) begin
        return_pc <= pc_vector;
      end else if (insn_done && !core_hold) begin
        return_pc <= return_pc + 16'h0003;
      end
    end
  end
endmodule : pic_core_model

// ### tb/pic_chk.sv
// Port-level assertions for the interrupt controller
`timescale 1ns/1ps
module pic_chk (
  // Clock and reset
  input wire logic        clk,
  input wire logic        srst,
  // Bus
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Core
  input wire logic        insn_done,
  input wire logic        brk_request,
  input wire logic [15:0] return_pc,
  input wire logic        core_hold,
  input wire logic        pc_load,
  input wire logic [15:0] pc_vector,
  input wire logic        stack_we,
  input wire logic [7:0]  stack_addr,
  input wire logic [7:0]  stack_wdata,
  input wire logic        master_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  a_hold_len: assert property (
    $rose(core_hold) |-> core_hold [*7] ##1 !core_hold) else $error("hold length wrong");
  a_push_walk: assert property (
    $rose(core_hold) |-> ##1 stack_we [*3] ##1 !stack_we [*3] ##1 pc_load)
    else $error("push sequence wrong");
  a_master_clear: assert property (
    $rose(core_hold) |-> !master_enable) else $error("master enable not cleared");
  a_push_data: assert property (
    $rose(core_hold) |-> ##1 stack_wdata == $past(return_pc[15:8], 2)
    ##1 stack_wdata == $past(return_pc[7:0], 3)) else $error("return address wrong");
  a_sp_step: assert property (
    stack_we && $past(stack_we) |-> stack_addr == $past(stack_addr) - 8'h01)
    else $error("stack pointer step wrong");
  a_brk_taken: assert property (
    insn_done && brk_request && !core_hold && !pc_load |=> core_hold)
    else $error("break not taken");
  a_gate_closed: assert property (
    insn_done && !brk_request && !master_enable && !core_hold && !pc_load |=> !core_hold)
    else $error("accepted with master enable low");
  a_vector_set: assert property (
    pc_load |-> pc_vector inside {16'hfffe, 16'hfffa, 16'hfff8, 16'hfff6, 16'hfff4,
    16'hfff2, 16'hffee, 16'hffec, 16'hffea, 16'hffe8, 16'hffe4, 16'hffe2, 16'hffe0,
    16'hffde}) else $error("vector outside table");
  a_bus_okay: assert property (
    hreadyout && !hresp) else $error("bus response not okay");

  c_accept: cover property ($rose(core_hold) ##1 stack_we);
  c_shared: cover property (pc_load && pc_vector == 16'hfff2);
  c_brk: cover property (insn_done && brk_request && !core_hold);
endmodule : pic_chk

bind pic_top pic_chk pic_chk_inst (.clk, .srst, .hreadyout, .hresp, .insn_done, .brk_request,
  .return_pc, .core_hold, .pc_load, .pc_vector, .stack_we, .stack_addr, .stack_wdata,
  .master_enable);

// ### tb/test_prioritized_interrupt_controller.sv
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps
module test_prioritized_interrupt_controller;
  logic        clk, srst, hwrite, hreadyout, hresp, insn_done, brk_request, rd_ph;
  logic        uart_rx_done, uart_tx_done, adc_done, interval_overflow, watchdog_match;
  logic        watch_period, watchdog_reset_select, core_hold, pc_load, stack_we;
  logic        master_enable, hsel, psw_restore;
  logic [2:0]  hsize;
  logic [1:0]  htrans;
  logic [3:0]  ext_pin, timer_match;
  logic [7:0]  stack_addr, stack_wdata, psw_restore_data;
  logic [15:0] return_pc, pc_vector, vec_t [14], vec_q [$];
  logic [31:0] haddr, hwdata, hrdata, rng, rd_q [$];
  int          mismatches, checked, cyc;

  pic_top pic_top_inst (.clk, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .ext_pin, .uart_rx_done,
    .uart_tx_done, .timer_match, .adc_done, .interval_overflow, .watchdog_match,
    .watchdog_reset_select, .watch_period, .insn_done, .brk_request, .return_pc,
    .psw_restore, .psw_restore_data, .core_hold, .pc_load, .pc_vector,
    .stack_we, .stack_addr, .stack_wdata, .master_enable);
  pic_core_model pic_core_model_inst (.clk, .srst, .core_hold, .pc_load, .pc_vector,
    .insn_done, .return_pc);

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    xs = t ^ (t << 5);
  endfunction : xs

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    haddr <= {24'h0, a};
    hwrite <= w;
    hsel <= 1'b1;
    hsize <= 3'h2;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    if (!w) rd_q.push_back(d);
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask : bus

  task automatic fire(input logic [13:0] m);
    @(posedge clk);
    ext_pin <= ext_pin ^ m[3:0];
    {watch_period, watchdog_match, interval_overflow, adc_done, timer_match,
      uart_tx_done, uart_rx_done} <= m[13:4];
    @(posedge clk);
    {watch_period, watchdog_match, interval_overflow, adc_done, timer_match,
      uart_tx_done, uart_rx_done} <= '0;
    repeat (8) @(posedge clk);
  endtask : fire

  task automatic drain();
    repeat (80) if (vec_q.size() != 0) @(posedge clk);
    if (vec_q.size() != 0) begin
      mismatches++;
      $display("MISMATCH at %0t: acceptance missing", $time);
      vec_q.delete();
    end
  endtask : drain

  task automatic clear_req();
    bus(1, 8'h0c, 0);
    bus(1, 8'h10, 0);
    bus(1, 8'h14, 0);
  endtask : clear_req

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Result watcher and hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      mismatches++;
      end_of_test();
    end
    if (rd_ph && hreadyout) chk(hrdata, rd_q.pop_front());
    if (hreadyout) rd_ph <= htrans[1] && !hwrite;
    if (pc_load === 1'b1) chk({16'h0, pc_vector},
      vec_q.size() ? {16'h0, vec_q.pop_front()} : 32'hffff_ffff);
  end

  initial begin
    {srst, hwrite, brk_request, rd_ph, watchdog_reset_select} = 5'h10;
    {uart_rx_done, uart_tx_done, adc_done, interval_overflow, watchdog_match} = 5'h00;
    {watch_period, htrans, ext_pin, timer_match, haddr, hwdata} = '0;
    {hsel, hsize, psw_restore, psw_restore_data} = '0;
    {mismatches, checked, cyc, rng} = {32'h0, 32'h0, 32'h0, 32'h51};
    vec_t = '{16'hfffa, 16'hfff8, 16'hfff6, 16'hfff4, 16'hfff2, 16'hfff2, 16'hffee,
      16'hffec, 16'hffea, 16'hffe8, 16'hffe4, 16'hffe2, 16'hffe0, 16'hffe0};
    vec_q.push_back(16'hfffe);
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    drain();
    bus(0, 8'h20, 0);
    bus(0, 8'h24, 32'hff);
    bus(0, 8'hfc, 0);
    bus(0, 8'h40, 0);
    $display("test reset values done");
    for (int m = 0; m < 4; m++) begin
      bus(1, 8'hfc, {24'h0, {4{m[1:0]}}});
      fire(14'h0001);
      bus(0, 8'h0c, m[1] ? 32'h40 : 32'h0);
      bus(1, 8'h0c, 0);
      fire(14'h0001);
      bus(0, 8'h0c, m[0] ? 32'h40 : 32'h0);
      bus(1, 8'h0c, 0);
    end
    $display("test edge modes done");
    rng = xs(rng);
    bus(1, 8'h10, {24'h0, rng[7:2], 2'h0});
    bus(0, 8'h10, {24'h0, rng[7:2], 2'h0});
    bus(1, 8'h10, 0);
    $display("test request write done");
    for (int a = 0; a < 3; a++) bus(1, 8'(a * 4), 32'hff);
    bus(1, 8'hfc, 32'hff);
    fire(14'h0010);
    repeat (40) @(posedge clk);
    bus(0, 8'h0c, 32'h08);
    bus(0, 8'h18, 32'h10);
    vec_q.push_back(16'hfff2);
    bus(1, 8'h20, 32'h04);
    drain();
    bus(0, 8'h0c, 32'h08);
    bus(0, 8'h18, 32'h10);
    bus(0, 8'h20, 0);
    bus(0, 8'h24, 32'hfc);
    $display("test shared vector done");
    for (int i = 0; i < 14; i++) begin
      clear_req();
      fire(14'h1 << i);
      vec_q.push_back(vec_t[i]);
      bus(1, 8'h20, 32'h04);
      drain();
    end
    $display("test each source done");
    clear_req();
    fire(14'h3fc0);
    vec_q.push_back(16'hffee);
    bus(1, 8'h20, 32'h04);
    drain();
    bus(1, 8'h10, 32'h7c);
    vec_q.push_back(16'hffec);
    bus(1, 8'h20, 32'h04);
    drain();
    clear_req();
    $display("test priority done");
    bus(1, 8'h00, 0);
    watchdog_reset_select <= 1'b1;
    fire(14'h1010);
    bus(1, 8'h20, 32'h04);
    repeat (40) @(posedge clk);
    bus(0, 8'h14, 0);
    watchdog_reset_select <= 1'b0;
    bus(1, 8'h20, 0);
    brk_request <= 1'b1;
    vec_q.push_back(16'hffde);
    drain();
    brk_request <= 1'b0;
    repeat (40) @(posedge clk);
    psw_restore_data <= 8'h04;
    psw_restore <= 1'b1;
    @(posedge clk);
    psw_restore <= 1'b0;
    bus(0, 8'h20, 32'h04);
    repeat (20) @(posedge clk);
    $display("test masking and break done");
    end_of_test();
  end
endmodule : test_prioritized_interrupt_controller
